/* rtl/cmsd_cfg.svh */
// Offsets, field positions, reset values and timing for the memory space decoder
`ifndef CMSD_CFG_SVH
`define CMSD_CFG_SVH
`define CMSD_SP_ADDR 8'h81
`define CMSD_PROGRAM_STORE_CONTROL_ADDR 8'h8f
`define CMSD_PSW_ADDR 8'hd0
`define CMSD_SP_RST 8'h07
`define CMSD_PSW_RST 8'h00
`define CMSD_PROGRAM_STORE_CONTROL_RST 8'h00
`define CMSD_BANK_LO 3
`define CMSD_BANK_HI 4
`define CMSD_PSWE_BIT 0
`define CMSD_PM_TOP 16'hfbff
`define CMSD_BITRAM_HI 4'h2
`define CMSD_RAM_DEPTH 256
`define CMSD_RSP_LAT 2
`endif

/* rtl/cmsd_pkg.sv */
// Types shared by the memory space decoder
package cmsd_pkg;
   // Addressing mode as issued by the instruction type
   typedef enum logic [2:0] {
      AM_DIRECT,
      AM_INDIRECT,
      AM_REG,
      AM_BIT,
      AM_PUSH,
      AM_POP,
      AM_CODE,
      AM_XMOVE
   } cmsd_mode_t;

   // Where the answer byte comes from
   typedef enum logic [2:0] {
      SRC_NONE,
      SRC_RAM,
      SRC_INT,
      SRC_EXT,
      SRC_PM
   } cmsd_src_t;

   typedef struct packed {
      logic valid;
      cmsd_mode_t mode;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cmsd_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
      logic rbit;
      logic err;
   } cmsd_rsp_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic bit_en;
      logic [2:0] bit_idx;
   } cmsd_sfr_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cmsd_pm_t;

   typedef struct packed {
      logic valid;
      cmsd_src_t src;
      logic [7:0] byte_val;
      logic bit_en;
      logic [2:0] bit_idx;
      logic err;
   } cmsd_stage_t;
endpackage

/* rtl/cmsd_data_ram.sv */
// Internal data RAM, 256 bytes, two asynchronous read ports, one write port
`timescale 1ns/1ps
`default_nettype none
`include "cmsd_cfg.svh"
module cmsd_data_ram
(
   input wire logic i_mclk,
   input wire logic i_we,
   input wire logic [7:0] i_aa,
   input wire logic [7:0] i_wd,
   output logic [7:0] o_ad,
   input wire logic [7:0] i_ab,
   output logic [7:0] o_bd
);
   // Storage has no reset; software must initialise what it uses
   logic [7:0] mem [0:`CMSD_RAM_DEPTH-1];

   // Port b fetches the index register for indirect modes
   assign o_ad = mem[i_aa];
   assign o_bd = mem[i_ab];

   // Write shares port a address so bit updates are read-modify-write
   always_ff @(posedge i_mclk)
   begin
      if (i_we)
      begin
         mem[i_aa] <= i_wd;
      end
   end
endmodule
`default_nettype wire

/* rtl/cmsd_sfr_regs.sv */
// Core special function registers: stack pointer, status word, program store control
`timescale 1ns/1ps
`default_nettype none
`include "cmsd_cfg.svh"
module cmsd_sfr_regs
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [7:0] i_addr,
   input wire logic i_we,
   input wire logic [7:0] i_wdata,
   input wire logic i_push,
   input wire logic i_pop,
   output logic o_hit,
   output logic [7:0] o_rdata,
   output logic [7:0] o_sp,
   output logic [7:0] o_psw,
   output logic [7:0] o_program_store_control
);
   logic [7:0] sp_reg;
   logic [7:0] sp_next;
   logic [7:0] psw_reg;
   logic [7:0] program_store_control_reg;
   logic hit_sp;
   logic hit_psw;
   logic hit_program_store_control;

   // Address match for the registers held here
   assign hit_sp = (i_addr == `CMSD_SP_ADDR);
   assign hit_psw = (i_addr == `CMSD_PSW_ADDR);
   assign hit_program_store_control = (i_addr == `CMSD_PROGRAM_STORE_CONTROL_ADDR);
   assign o_hit = hit_sp | hit_psw | hit_program_store_control;
   assign o_rdata = hit_sp ? sp_reg : hit_psw ? psw_reg : hit_program_store_control ? program_store_control_reg : 8'h00;

   // Pointer names the last used slot: push pre-increments, pop post-decrements
   assign sp_next = (i_we & hit_sp) ? i_wdata :
                    i_push ? sp_reg + 8'h01 :
                    i_pop ? sp_reg - 8'h01 : sp_reg;

   // Register update; reset value makes the first push land in bank 1
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         sp_reg <= `CMSD_SP_RST;
         psw_reg <= `CMSD_PSW_RST;
         program_store_control_reg <= `CMSD_PROGRAM_STORE_CONTROL_RST;
      end
      else
      begin
         sp_reg <= sp_next;
         if (i_we & hit_psw)
         begin
            psw_reg <= i_wdata;
         end
         if (i_we & hit_program_store_control)
         begin
            program_store_control_reg <= i_wdata;
         end
      end
   end

   assign o_sp = sp_reg;
   assign o_psw = psw_reg;
   assign o_program_store_control = program_store_control_reg;
endmodule
`default_nettype wire

/* rtl/cmsd_top.sv */
// Memory space decoder: program/data split, RAM, banks, bit space, stack
// What this block does
// - Instruction type, not address, selects memory space
// - Full variant: code above 0xFBFF is reserved
// - External-move writes code only when enabled
// - 256 bytes internal RAM at 0x00-0xFF
// - Lower 128 bytes: direct and indirect access
// - Upper 128 bytes: indirect only, separate storage
// - Direct above 0x7F goes to SFR space
// - Four banks of eight, status bits select
// - Indirect address from bank's index register 0/1
// - Bytes 0x20-0x2F form bit addresses 0x00-0x7F
// - Bit versus byte set by instruction type
// - Pointer holds last slot; push at plus one
// - Reset loads stack pointer with 0x07
// - Stack pointer at 0x81; stack anywhere
// - Only SFRs ending 0x0/0x8 are bit-addressable
`timescale 1ns/1ps
`default_nettype none
`include "cmsd_cfg.svh"
module cmsd_top #(
   parameter bit FULL_64K = 1'b1
)
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire cmsd_pkg::cmsd_req_t i_req,
   input wire logic [7:0] i_sfr_rdata,
   input wire logic [7:0] i_pm_rdata,
   output var cmsd_pkg::cmsd_rsp_t o_rsp,
   output var cmsd_pkg::cmsd_sfr_t o_sfr,
   output var cmsd_pkg::cmsd_pm_t o_pm,
   output logic [7:0] o_psw,
   output logic [7:0] o_sp
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   logic go;
   logic is_dir;
   logic is_ind;
   logic is_reg;
   logic is_bit;
   logic is_push;
   logic is_pop;
   logic is_code;
   logic is_xmv;
   logic hi_half;
   logic [1:0] bank;
   logic [7:0] ptr_addr;
   logic [7:0] ptr_data;
   logic [7:0] ram_aa;
   logic [7:0] ram_ad;
   logic ram_sel;
   logic ram_we;
   logic sfr_sel;
   logic [7:0] sfr_addr;
   logic int_hit;
   logic [7:0] int_rdata;
   logic int_we;
   logic ext_go;
   logic [7:0] cur_byte;
   logic [2:0] bit_idx;
   logic [7:0] bit_mask;
   logic [7:0] merged;
   logic [7:0] wr_byte;
   logic [7:0] psw_q;
   logic [7:0] sp_q;
   logic [7:0] program_store_control_q;
   logic pm_res;
   logic pm_rd;
   logic pm_wr;
   logic req_err;
   logic [7:0] rsp_byte;
   cmsd_pkg::cmsd_src_t src_next;
   cmsd_pkg::cmsd_stage_t s1_reg;
   cmsd_pkg::cmsd_stage_t s1_next;
   cmsd_pkg::cmsd_rsp_t rsp_next;
   cmsd_pkg::cmsd_sfr_t sfr_next;
   cmsd_pkg::cmsd_pm_t pm_next;

   // Mode decode; the space follows the mode alone
   assign go = i_req.valid;
   assign is_dir = (i_req.mode == cmsd_pkg::AM_DIRECT);
   assign is_ind = (i_req.mode == cmsd_pkg::AM_INDIRECT);
   assign is_reg = (i_req.mode == cmsd_pkg::AM_REG);
   assign is_bit = (i_req.mode == cmsd_pkg::AM_BIT);
   assign is_push = (i_req.mode == cmsd_pkg::AM_PUSH);
   assign is_pop = (i_req.mode == cmsd_pkg::AM_POP);
   assign is_code = (i_req.mode == cmsd_pkg::AM_CODE);
   assign is_xmv = (i_req.mode == cmsd_pkg::AM_XMOVE);
   assign hi_half = i_req.addr[7];

   // Active bank and its index register for indirect modes
   assign bank = psw_q[`CMSD_BANK_HI:`CMSD_BANK_LO];
   assign ptr_addr = {3'b000, bank, 2'b00, i_req.addr[0]};

   // Direct or bit access in the upper half names the SFR space
   assign sfr_sel = go & (is_dir | is_bit) & hi_half;
   // Bit addresses 0x80+ pick a register ending in 0x0 or 0x8
   assign sfr_addr = is_bit ? {i_req.addr[7:3], 3'b000} : i_req.addr[7:0];
   assign int_we = sfr_sel & int_hit & i_req.write;
   // Unclaimed SFR addresses go out; reserved ones are software's problem
   assign ext_go = sfr_sel & ~int_hit;

   // RAM select: indirect and stack reach all 256 bytes, direct only the low half
   assign ram_sel = go & (is_ind | is_reg | is_push | is_pop |
                         ((is_dir | is_bit) & ~hi_half));
   assign ram_aa = is_ind ? ptr_data :
                   is_reg ? {3'b000, bank, i_req.addr[2:0]} :
                   is_bit ? {`CMSD_BITRAM_HI, i_req.addr[6:3]} :
                   is_push ? sp_q + 8'h01 :
                   is_pop ? sp_q :
                   i_req.addr[7:0];
   assign ram_we = ram_sel & (i_req.write | is_push) & ~is_pop;

   // Bit writes merge one bit into the current byte
   assign bit_idx = i_req.addr[2:0];
   assign bit_mask = 8'h01 << bit_idx;
   assign cur_byte = sfr_sel ? (int_hit ? int_rdata : 8'h00) : ram_ad;
   assign merged = (cur_byte & ~bit_mask) | (i_req.wdata[0] ? bit_mask : 8'h00);
   assign wr_byte = is_bit ? merged : i_req.wdata;

   // Program space: read-only unless the store write enable is set
   assign pm_res = FULL_64K & (i_req.addr > `CMSD_PM_TOP);
   assign pm_rd = go & is_code & ~pm_res;
   assign pm_wr = go & is_xmv & i_req.write & program_store_control_q[`CMSD_PSWE_BIT] & ~pm_res;
   assign req_err = go & pm_res & (is_code | (is_xmv & i_req.write &
                                               program_store_control_q[`CMSD_PSWE_BIT]));

   // Answer source for stage one
   assign src_next = ram_sel ? cmsd_pkg::SRC_RAM :
                     (sfr_sel & int_hit) ? cmsd_pkg::SRC_INT :
                     ext_go ? cmsd_pkg::SRC_EXT :
                     pm_rd ? cmsd_pkg::SRC_PM : cmsd_pkg::SRC_NONE;

   // Stage one carries the local byte; outside data is taken one cycle later
   always_comb
   begin
      s1_next.valid = go;
      s1_next.src = src_next;
      s1_next.byte_val = cur_byte;
      s1_next.bit_en = go & is_bit;
      s1_next.bit_idx = bit_idx;
      s1_next.err = req_err;
   end

   // Outside SFR request; the owner does its own bit merge
   always_comb
   begin
      sfr_next.valid = ext_go;
      sfr_next.write = i_req.write;
      sfr_next.addr = sfr_addr;
      sfr_next.wdata = i_req.wdata;
      sfr_next.bit_en = is_bit;
      sfr_next.bit_idx = bit_idx;
   end

   // Program store strobes
   always_comb
   begin
      pm_next.rd = pm_rd;
      pm_next.wr = pm_wr;
      pm_next.addr = i_req.addr;
      pm_next.wdata = i_req.wdata;
   end

   // Answer: two cycles after the request, every mode alike
   assign rsp_byte = (s1_reg.src == cmsd_pkg::SRC_EXT) ? i_sfr_rdata :
                     (s1_reg.src == cmsd_pkg::SRC_PM) ? i_pm_rdata :
                     (s1_reg.src == cmsd_pkg::SRC_NONE) ? 8'h00 : s1_reg.byte_val;
   always_comb
   begin
      rsp_next.valid = s1_reg.valid;
      rsp_next.rdata = rsp_byte;
      rsp_next.rbit = s1_reg.bit_en & rsp_byte[s1_reg.bit_idx];
      rsp_next.err = s1_reg.err;
   end

   // Pipeline registers; every output except o_psw and o_sp leaves from here
   always_ff @(posedge i_mclk)
   begin
      if (!i_nrst)
      begin
         s1_reg <= '0;
         o_rsp <= '0;
         o_sfr <= '0;
         o_pm <= '0;
      end
      else
      begin
         s1_reg <= s1_next;
         o_rsp <= rsp_next;
         o_sfr <= sfr_next;
         o_pm <= pm_next;
      end
   end

   // 256-byte RAM; upper half never meets the SFR registers
   cmsd_data_ram u_ram (
      .i_mclk(i_mclk),
      .i_we(ram_we),
      .i_aa(ram_aa),
      .i_wd(wr_byte),
      .o_ad(ram_ad),
      .i_ab(ptr_addr),
      .o_bd(ptr_data)
   );

   // Core registers; stack pointer moves on push and pop
   cmsd_sfr_regs u_regs (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_addr(sfr_addr),
      .i_we(int_we),
      .i_wdata(wr_byte),
      .i_push(go & is_push),
      .i_pop(go & is_pop),
      .o_hit(int_hit),
      .o_rdata(int_rdata),
      .o_sp(sp_q),
      .o_psw(psw_q),
      .o_program_store_control(program_store_control_q)
   );

   // Straight from the register flops in the sub-module
   assign o_psw = psw_q;
   assign o_sp = sp_q;

   // Checks on the decode and stack behaviour
   AST_RSP_LAT: assert property (go |-> ##2 o_rsp.valid)
      else $error("answer not two cycles after request");
   AST_CODE_NO_SFR: assert property (go && is_code |=> !o_sfr.valid ##1 !o_rsp.err ||
                                     $past(pm_res, 2))
      else $error("code access leaked to SFR space");
   AST_PM_RES: assert property (o_pm.wr && FULL_64K |-> o_pm.addr <= 16'hfbff)
      else $error("write into reserved program space");
   AST_PM_GATE: assert property (go && is_xmv && i_req.write && !program_store_control_q[0]
                                 |=> !o_pm.wr)
      else $error("program write without enable");
   AST_IND_RAM: assert property (go && is_ind |-> ram_aa == ptr_data ##1 !o_sfr.valid)
      else $error("indirect access reached SFR space");
   AST_DIR_SFR: assert property (go && is_dir && hi_half && !int_hit |-> !ram_we
                                 ##1 o_sfr.valid && o_sfr.addr == $past(i_req.addr[7:0]))
      else $error("direct upper access not sent to SFR");
   AST_LOW_DIR: assert property (go && is_dir && !hi_half |-> ram_sel && ram_aa == i_req.addr[7:0])
      else $error("direct lower access not sent to RAM");
   AST_POP: assert property (go && is_pop |-> !ram_we ##1 sp_q == $past(sp_q) - 8'h01)
      else $error("pop wrote RAM or pointer step wrong");
   AST_BANK: assert property (go && is_reg |-> ram_aa == {3'b000, psw_q[4:3], i_req.addr[2:0]})
      else $error("register access outside active bank");
   AST_BITMAP: assert property (go && is_bit && !hi_half
                                |-> ram_aa == {4'h2, i_req.addr[6:3]})
      else $error("bit address maps to wrong byte");
   AST_PUSH: assert property (go && is_push |-> ram_we && ram_aa == sp_q + 8'h01
                              ##1 sp_q == $past(sp_q) + 8'h01)
      else $error("push slot or pointer step wrong");
   AST_SP_RST: assert property ($rose(i_nrst) |-> sp_q == 8'h07)
      else $error("stack pointer not 0x07 after reset");
   AST_SFR_BIT: assert property (o_sfr.valid && o_sfr.bit_en |-> o_sfr.addr[2:0] == 3'b000)
      else $error("bit access to non bit-addressable SFR");

   COV_PUSH: cover property (go && is_push ##1 go && is_pop);
   COV_IND_HI: cover property (go && is_ind && ram_aa[7] && ram_we);
   COV_SFR_BIT: cover property (go && is_bit && hi_half && i_req.write);
   COV_PM_WR: cover property (o_pm.wr);
endmodule
`default_nettype wire

/* tb/cmsd_far_model.sv */
// Behavioural model of the outside register owner and the program store
`timescale 1ns/1ps
`default_nettype none
module cmsd_far_model
(
   input wire logic i_mclk,
   input wire cmsd_pkg::cmsd_sfr_t i_sfr,
   input wire cmsd_pkg::cmsd_pm_t i_pm,
   output logic [7:0] o_sfr_rdata,
   output logic [7:0] o_pm_rdata
);
   logic [7:0] sfr_mem [256];
   logic [7:0] pm_mem [256];
   logic [7:0] churn = 8'h00;
   // Store preload is a known pattern so reads can be predicted
   initial
   begin
      for (int i = 0; i < 256; i++)
      begin
         pm_mem[i] = 8'(i) ^ 8'h5a;
         sfr_mem[i] = 8'h00;
      end
   end
   // Idle lines churn so a late sample never passes for an answer
   assign o_sfr_rdata = (i_sfr.valid && !i_sfr.write) ? sfr_mem[i_sfr.addr] : churn;
   assign o_pm_rdata = i_pm.rd ? pm_mem[i_pm.addr[7:0]] : ~churn;
   // Owner merges bit writes itself; store keeps only the low address byte
   always @(posedge i_mclk)
   begin
      churn <= churn + 8'h01;
      if (i_sfr.valid && i_sfr.write && i_sfr.bit_en)
         sfr_mem[i_sfr.addr][i_sfr.bit_idx] <= i_sfr.wdata[0];
      else if (i_sfr.valid && i_sfr.write)
         sfr_mem[i_sfr.addr] <= i_sfr.wdata;
      if (i_pm.wr)
         pm_mem[i_pm.addr[7:0]] <= i_pm.wdata;
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the memory space decoder
`timescale 1ns/1ps
`default_nettype none
`include "cmsd_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("MISMATCH %0t got %h want %h", $time, (a), (b)); end end
module testbench;
   localparam cmsd_pkg::cmsd_mode_t D = cmsd_pkg::AM_DIRECT;
   localparam cmsd_pkg::cmsd_mode_t I = cmsd_pkg::AM_INDIRECT;
   localparam cmsd_pkg::cmsd_mode_t R = cmsd_pkg::AM_REG;
   localparam cmsd_pkg::cmsd_mode_t B = cmsd_pkg::AM_BIT;
   localparam cmsd_pkg::cmsd_mode_t C = cmsd_pkg::AM_CODE;
   localparam cmsd_pkg::cmsd_mode_t X = cmsd_pkg::AM_XMOVE;
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   cmsd_pkg::cmsd_req_t req = '0;
   cmsd_pkg::cmsd_rsp_t rsp;
   cmsd_pkg::cmsd_sfr_t sfr;
   cmsd_pkg::cmsd_pm_t pm;
   logic [7:0] sfr_rdata;
   logic [7:0] pm_rdata;
   logic [7:0] processor_status_word;
   logic [7:0] sp;
   logic [7:0] rd;
   logic rb;
   logic er;
   int bad_count = 0;
   int num_checks = 0;
   always #5 i_mclk = ~i_mclk;
   cmsd_top cmsd_top_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req(req),
      .i_sfr_rdata(sfr_rdata), .i_pm_rdata(pm_rdata), .o_rsp(rsp), .o_sfr(sfr),
      .o_pm(pm), .o_psw(processor_status_word), .o_sp(sp));
   cmsd_far_model cmsd_far_model_i (.i_mclk(i_mclk), .i_sfr(sfr), .i_pm(pm),
      .o_sfr_rdata(sfr_rdata), .o_pm_rdata(pm_rdata));
   // Verdict and end of run
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // One request, strobe held for a single cycle, answer awaited with a bound
   task automatic xfer(input cmsd_pkg::cmsd_mode_t m, input logic w, input logic [15:0] a,
      input logic [7:0] d);
      int n;
      @(negedge i_mclk);
      req = '{1'b1, m, w, a, d};
      @(negedge i_mclk);
      req.valid = 1'b0;
      n = 0;
      while (rsp.valid !== 1'b1 && n < 4)
      begin
         @(negedge i_mclk);
         n++;
      end
      if (rsp.valid !== 1'b1)
      begin
         bad_count++;
         $display("MISMATCH %0t no answer", $time);
         close_out;
      end
      else
      begin
         rd = rsp.rdata;
         rb = rsp.rbit;
         er = rsp.err;
      end
   endtask
   // Main sequence
   initial
   begin
      repeat (8) @(posedge i_mclk);
      @(negedge i_mclk);
      i_nrst = 1'b1;
      `CHK(sp, 8'h07)
      `CHK(processor_status_word, 8'h00)
      xfer(D, 1'b0, {8'h00, `CMSD_SP_ADDR}, 8'h00);
      `CHK(rd, 8'h07)
      // Lower half by direct and by index register zero
      xfer(D, 1'b1, 16'h0030, 8'ha5);
      xfer(D, 1'b1, 16'h0000, 8'h30);
      xfer(I, 1'b0, 16'h0000, 8'h00);
      `CHK(rd, 8'ha5)
      // Upper RAM and the register at the same address stay apart
      xfer(D, 1'b1, 16'h0001, 8'he0);
      xfer(I, 1'b1, 16'h0001, 8'h3c);
      xfer(D, 1'b1, 16'h00e0, 8'h77);
      xfer(D, 1'b0, 16'h00e0, 8'h00);
      `CHK(rd, 8'h77)
      xfer(I, 1'b0, 16'h0001, 8'h00);
      `CHK(rd, 8'h3c)
      // Every bank keeps its own working register three
      for (int b = 0; b < 4; b++)
         xfer(D, 1'b1, {11'h000, b[1:0], 3'h3}, {6'h10, b[1:0]});
      for (int b = 0; b < 4; b++)
      begin
         xfer(D, 1'b1, {8'h00, `CMSD_PSW_ADDR}, {3'h0, b[1:0], 3'h0});
         `CHK(processor_status_word, {3'h0, b[1:0], 3'h0})
         xfer(R, 1'b0, 16'h0003, 8'h00);
         `CHK(rd, {6'h10, b[1:0]})
      end
      // Bank three: index register one, then status bits by bit address
      xfer(D, 1'b1, 16'h0019, 8'h30);
      xfer(I, 1'b0, 16'h0001, 8'h00);
      `CHK(rd, 8'ha5)
      xfer(B, 1'b0, 16'h00d3, 8'h00);
      `CHK(rb, 1'b1)
      xfer(B, 1'b0, 16'h00d5, 8'h00);
      `CHK(rb, 1'b0)
      xfer(D, 1'b1, 16'h00d0, 8'h00);
      // Bit space over bytes 0x20 to 0x2f
      xfer(D, 1'b1, 16'h0022, 8'h08);
      xfer(B, 1'b0, 16'h0013, 8'h00);
      `CHK(rb, 1'b1)
      xfer(B, 1'b0, 16'h0012, 8'h00);
      `CHK(rb, 1'b0)
      xfer(D, 1'b1, 16'h002f, 8'h00);
      xfer(B, 1'b1, 16'h007f, 8'h01);
      xfer(D, 1'b0, 16'h002f, 8'h00);
      `CHK(rd, 8'h80)
      xfer(B, 1'b1, 16'h00e3, 8'h01);
      xfer(D, 1'b0, 16'h00e0, 8'h00);
      `CHK(rd, 8'h7f)
      // Stack from reset, then moved clear of the banks
      xfer(cmsd_pkg::AM_PUSH, 1'b1, 16'h0000, 8'h5a);
      `CHK(sp, 8'h08)
      xfer(D, 1'b0, 16'h0008, 8'h00);
      `CHK(rd, 8'h5a)
      xfer(cmsd_pkg::AM_POP, 1'b0, 16'h0000, 8'h00);
      `CHK(rd, 8'h5a)
      `CHK(sp, 8'h07)
      xfer(D, 1'b1, 16'h0081, 8'hbf);
      xfer(cmsd_pkg::AM_PUSH, 1'b1, 16'h0000, 8'h99);
      xfer(D, 1'b1, 16'h0000, 8'hc0);
      xfer(I, 1'b0, 16'h0000, 8'h00);
      `CHK(rd, 8'h99)
      // Program store: space by instruction, write gate, reserved top
      xfer(C, 1'b0, 16'h1234, 8'h00);
      `CHK(rd, 8'h6e)
      xfer(D, 1'b1, 16'h0034, 8'h66);
      xfer(D, 1'b0, 16'h0034, 8'h00);
      `CHK(rd, 8'h66)
      xfer(X, 1'b1, 16'h1234, 8'hc3);
      xfer(C, 1'b0, 16'h1234, 8'h00);
      `CHK(rd, 8'h6e)
      xfer(D, 1'b1, {8'h00, `CMSD_PROGRAM_STORE_CONTROL_ADDR}, 8'h01);
      xfer(X, 1'b1, 16'h1234, 8'hc3);
      xfer(C, 1'b0, 16'h1234, 8'h00);
      `CHK(rd, 8'hc3)
      xfer(C, 1'b0, 16'hfbff, 8'h00);
      `CHK(er, 1'b0)
      xfer(C, 1'b0, 16'hfc00, 8'h00);
      `CHK(er, 1'b1)
      xfer(X, 1'b1, 16'hffff, 8'h11);
      `CHK(er, 1'b1)
      // External-move read reaches neither store; byte reads carry no bit
      xfer(X, 1'b0, 16'h1234, 8'h00);
      `CHK(rd, 8'h00)
      `CHK(rb, 1'b0)
      // Mid-run reset returns the pointer to 0x07 and clears status and the store write enable
      @(negedge i_mclk);
      i_nrst = 1'b0;
      repeat (2) @(negedge i_mclk);
      i_nrst = 1'b1;
      `CHK(sp, 8'h07)
      `CHK(processor_status_word, 8'h00)
      xfer(X, 1'b1, 16'h1235, 8'h44);
      xfer(C, 1'b0, 16'h1235, 8'h00);
      `CHK(rd, 8'h6f)
      close_out;
   end
endmodule
`default_nettype wire
